//--- core/bridge_diag_cfg_regs.sv
/*
  Device control, diagnostic and capability-head configuration registers,
  with the socket, interrupt, retry and discard logic they steer.
  Assumes single-cycle configuration read and write strobes on i_mclk.
*/
// How it works
// (RULE1) Power hold blocks socket power-off in D3
// (RULE2) Low-voltage bit reports 3-V capability, resets 1
// (RULE3) IO width select is read/write, resets 1
// (RULE4) Software writes only 0 to test bit 3
// (RULE5) Two-bit select picks four interrupt modes
// (RULE6) Device control bit 4 reads 0
// (RULE7) Bit 0 kept read/write; software writes 0
// (RULE8) Software writes 00h to diagnostic register
// (RULE9) ID mask makes vendor/device reads all ones
// (RULE10) Diagnostic bit 6 always reads 1
// (RULE11) Status-change routing picks legacy register condition
// (RULE12) Disable bit stops delayed-transaction handling
// (RULE13) Extend bit raises retry latency 16 to 64
// (RULE14) Card discard timer 2^10 set, 2^15 clear
// (RULE15) Host discard timer 2^10 set, 2^15 clear
// (RULE16) Video model disable bit turns model off
// (RULE17) Capability identifier reads constant 01h
// (RULE18) Next-capability link reads constant 00h
// (RULE19) Timeouts counted in clock cycles, default 2^15
// (RULE20) Capability byte writes complete, values unchanged
`timescale 1ns/1ps
module bridge_diag_cfg_regs #(
  parameter int DISCARD_LONG_CYCLES = bridge_diag_cfg_pkg::DISCARD_LONG_CYCLES,
  parameter int DISCARD_SHORT_CYCLES = bridge_diag_cfg_pkg::DISCARD_SHORT_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_ack,
  output logic o_cfg_hit,
  input wire logic [15:0] i_vendor_id,
  input wire logic [15:0] i_device_id,
  input wire logic i_in_d3,
  input wire logic i_sw_socket_power_off,
  input wire logic i_sw_socket_power_on,
  output logic o_socket_power_off,
  output logic o_low_voltage_socket_capable,
  output logic o_diag_io_width_select,
  output logic o_par_pci_en,
  output logic o_par_irq_en,
  output logic o_ser_irq_en,
  output logic o_ser_pci_en,
  input wire logic i_csc_event,
  input wire logic i_legacy_803_bit4,
  input wire logic [3:0] i_legacy_805_hi,
  output logic o_csc_to_host,
  input wire logic i_host_retry,
  output logic o_delayed_txn_capture,
  input wire logic i_host_master_return,
  input wire logic i_card_retry,
  input wire logic i_card_master_return,
  output logic o_host_discard_expired,
  output logic o_card_discard_expired,
  input wire logic i_target_wait,
  output logic o_retry_latency_expired,
  output logic o_std_video_model_en
);

  localparam int TMR_W = $clog2(DISCARD_LONG_CYCLES + 1);
  localparam int LAT_W = $clog2(bridge_diag_cfg_pkg::RETRY_LAT_LONG + 1);

  logic [7:0] dev_ctrl_ff;
  logic [7:0] diag_ff;
  logic [7:0] nxt_dev_ctrl;
  logic [7:0] nxt_diag;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic ack_ff;
  logic power_off_ff;
  logic txn_capture_ff;
  logic [LAT_W-1:0] lat_cnt_ff;
  logic lat_exp_ff;
  logic [LAT_W-1:0] lat_limit;
  logic hit_id;
  logic hit_dc;
  logic hit_cap;
  logic host_tmr_start;
  logic card_tmr_start;

  // ****************************************
  // Address decode
  // ****************************************
  assign hit_id = (bridge_diag_cfg_pkg::dword_of(i_cfg_addr) ==
                   bridge_diag_cfg_pkg::dword_of(bridge_diag_cfg_pkg::OFS_VENDOR_ID));
  assign hit_dc = (bridge_diag_cfg_pkg::dword_of(i_cfg_addr) ==
                   bridge_diag_cfg_pkg::dword_of(bridge_diag_cfg_pkg::OFS_RETRY_STATUS));
  assign hit_cap = (bridge_diag_cfg_pkg::dword_of(i_cfg_addr) ==
                    bridge_diag_cfg_pkg::dword_of(bridge_diag_cfg_pkg::OFS_CAP_ID));
  assign o_cfg_hit = hit_id || hit_dc || hit_cap;

  // ****************************************
  // Register writes
  // ****************************************
  always_comb begin
    nxt_dev_ctrl = dev_ctrl_ff;
    nxt_diag = diag_ff;
    if (i_cfg_wr && hit_dc) begin
      if (i_cfg_be[bridge_diag_cfg_pkg::OFS_DEVICE_CONTROL[1:0]]) begin
        // Test bits 3 and 0 stay writable; bit 4 is never stored
        nxt_dev_ctrl = i_cfg_wdata[8*bridge_diag_cfg_pkg::OFS_DEVICE_CONTROL[1:0] +: 8] &
                       bridge_diag_cfg_pkg::DC_WRITE_MASK; // (RULE3) (RULE6) (RULE7)
      end
      if (i_cfg_be[bridge_diag_cfg_pkg::OFS_DIAGNOSTIC[1:0]]) begin
        nxt_diag = i_cfg_wdata[8*bridge_diag_cfg_pkg::OFS_DIAGNOSTIC[1:0] +: 8] &
                   bridge_diag_cfg_pkg::DG_WRITE_MASK; // (RULE8)
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      dev_ctrl_ff <= bridge_diag_cfg_pkg::DC_RESET; // (RULE2) (RULE3) (RULE5)
    end else begin
      dev_ctrl_ff <= nxt_dev_ctrl;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      diag_ff <= bridge_diag_cfg_pkg::DG_RESET; // (RULE9) (RULE11)
    end else begin
      diag_ff <= nxt_diag;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_id) begin
      nxt_rdata = diag_ff[bridge_diag_cfg_pkg::DG_ID_MASK_POS] ? 32'hFFFF_FFFF // (RULE9)
                                                               : {i_device_id, i_vendor_id};
    end else if (hit_dc) begin
      nxt_rdata[8*bridge_diag_cfg_pkg::OFS_DEVICE_CONTROL[1:0] +: 8] =
        dev_ctrl_ff & bridge_diag_cfg_pkg::DC_WRITE_MASK; // (RULE6)
      nxt_rdata[8*bridge_diag_cfg_pkg::OFS_DIAGNOSTIC[1:0] +: 8] =
        diag_ff | bridge_diag_cfg_pkg::DG_READ_ONE; // (RULE10)
    end else if (hit_cap) begin
      // Writes here are accepted and leave these bytes as they are
      nxt_rdata[8*bridge_diag_cfg_pkg::OFS_CAP_ID[1:0] +: 8] =
        bridge_diag_cfg_pkg::CAP_ID_VALUE; // (RULE17) (RULE20)
      nxt_rdata[8*bridge_diag_cfg_pkg::OFS_NEXT_CAP[1:0] +: 8] =
        bridge_diag_cfg_pkg::NEXT_CAP_VALUE; // (RULE18) (RULE20)
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_cfg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= i_cfg_rd || i_cfg_wr; // (RULE20)
    end
  end

  assign o_cfg_rdata = rdata_ff;
  assign o_cfg_ack = ack_ff;

  // ****************************************
  // Socket power
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      power_off_ff <= 1'b0;
    end else if (i_sw_socket_power_off &&
                 !(dev_ctrl_ff[bridge_diag_cfg_pkg::DC_POWER_HOLD_POS] && i_in_d3)) begin
      power_off_ff <= 1'b1; // (RULE1)
    end else if (i_sw_socket_power_on) begin
      power_off_ff <= 1'b0;
    end
  end

  assign o_socket_power_off = power_off_ff;
  assign o_low_voltage_socket_capable =
    dev_ctrl_ff[bridge_diag_cfg_pkg::DC_LOW_VOLTAGE_POS]; // (RULE2)
  assign o_diag_io_width_select = dev_ctrl_ff[bridge_diag_cfg_pkg::DC_IO_WIDTH_POS]; // (RULE3)
  assign o_std_video_model_en =
    !diag_ff[bridge_diag_cfg_pkg::DG_VIDEO_DIS_POS]; // (RULE16)

  // ****************************************
  // Interrupt routing
  // ****************************************
  irq_route u_irq_route (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_irq_signalling_select(dev_ctrl_ff[bridge_diag_cfg_pkg::DC_IRQ_SEL_LSB +: 2]),
    .i_card_status_change_routing(diag_ff[bridge_diag_cfg_pkg::DG_CSC_ROUTE_POS]),
    .i_legacy_803_bit4(i_legacy_803_bit4),
    .i_legacy_805_hi(i_legacy_805_hi),
    .i_csc_event(i_csc_event),
    .o_csc_to_host(o_csc_to_host),
    .o_par_pci_en(o_par_pci_en),
    .o_par_irq_en(o_par_irq_en),
    .o_ser_irq_en(o_ser_irq_en),
    .o_ser_pci_en(o_ser_pci_en)
  );

  // ****************************************
  // Delayed transactions
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      txn_capture_ff <= 1'b0;
    end else begin
      txn_capture_ff <= i_host_retry &&
                        !diag_ff[bridge_diag_cfg_pkg::DG_TXN_DIS_POS]; // (RULE12)
    end
  end

  assign o_delayed_txn_capture = txn_capture_ff;

  // ****************************************
  // Retry latency
  // ****************************************
  assign lat_limit = diag_ff[bridge_diag_cfg_pkg::DG_RETRY_LATENCY_EXTEND_POS] ?
                     LAT_W'(bridge_diag_cfg_pkg::RETRY_LAT_LONG - 1) :
                     LAT_W'(bridge_diag_cfg_pkg::RETRY_LAT_SHORT - 1); // (RULE13)

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      lat_cnt_ff <= '0;
    end else if (!i_target_wait) begin
      lat_cnt_ff <= '0;
    end else if (lat_cnt_ff < lat_limit) begin
      lat_cnt_ff <= lat_cnt_ff + LAT_W'(1); // (RULE19)
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      lat_exp_ff <= 1'b0;
    end else begin
      lat_exp_ff <= i_target_wait && (lat_cnt_ff == lat_limit) && !lat_exp_ff &&
                    (lat_cnt_ff != '0 || lat_limit == '0); // (RULE13)
    end
  end

  assign o_retry_latency_expired = lat_exp_ff;

  // ****************************************
  // Discard timers
  // ****************************************
  assign host_tmr_start = i_host_retry && !diag_ff[bridge_diag_cfg_pkg::DG_TXN_DIS_POS];
  assign card_tmr_start = i_card_retry && !diag_ff[bridge_diag_cfg_pkg::DG_TXN_DIS_POS];

  discard_timer #(
    .CNT_W(TMR_W),
    .LONG_CYCLES(DISCARD_LONG_CYCLES),
    .SHORT_CYCLES(DISCARD_SHORT_CYCLES)
  ) u_host_discard (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_start(host_tmr_start),
    .i_done(i_host_master_return),
    .i_short_sel(diag_ff[bridge_diag_cfg_pkg::DG_HOST_TIM_POS]), // (RULE15) (RULE19)
    .o_running(),
    .o_expired(o_host_discard_expired)
  );

  discard_timer #(
    .CNT_W(TMR_W),
    .LONG_CYCLES(DISCARD_LONG_CYCLES),
    .SHORT_CYCLES(DISCARD_SHORT_CYCLES)
  ) u_card_discard (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_start(card_tmr_start),
    .i_done(i_card_master_return),
    .i_short_sel(diag_ff[bridge_diag_cfg_pkg::DG_CARD_TIM_POS]), // (RULE14) (RULE19)
    .o_running(),
    .o_expired(o_card_discard_expired)
  );

endmodule : bridge_diag_cfg_regs

//--- core/bridge_diag_cfg_pkg.sv
/*
  Constants for the device control, diagnostic and capability-head slice
  of the bridge configuration space.
  Assumes dword-aligned configuration accesses with byte enables.
*/
package bridge_diag_cfg_pkg;

  // ****************************************
  // Configuration offsets
  // ****************************************
  localparam logic [7:0] OFS_VENDOR_ID = 8'h00;
  localparam logic [7:0] OFS_RETRY_STATUS = 8'h90;
  localparam logic [7:0] OFS_DEVICE_CONTROL = 8'h92;
  localparam logic [7:0] OFS_DIAGNOSTIC = 8'h93;
  localparam logic [7:0] OFS_CAP_ID = 8'hA0;
  localparam logic [7:0] OFS_NEXT_CAP = 8'hA1;

  // ****************************************
  // Device control fields
  // ****************************************
  localparam int DC_POWER_HOLD_POS = 7;
  localparam int DC_LOW_VOLTAGE_POS = 6;
  localparam int DC_IO_WIDTH_POS = 5;
  localparam int DC_RSVD4_POS = 4;
  localparam int DC_TEST_POS = 3;
  localparam int DC_IRQ_SEL_LSB = 1;
  localparam int DC_TEST0_POS = 0;
  localparam logic [7:0] DC_RESET = 8'h66;
  localparam logic [7:0] DC_WRITE_MASK = 8'hEF;

  // ****************************************
  // Diagnostic fields
  // ****************************************
  localparam int DG_ID_MASK_POS = 7;
  localparam int DG_RSVD6_POS = 6;
  localparam int DG_CSC_ROUTE_POS = 5;
  localparam int DG_TXN_DIS_POS = 4;
  localparam int DG_RETRY_LATENCY_EXTEND_POS = 3;
  localparam int DG_CARD_TIM_POS = 2;
  localparam int DG_HOST_TIM_POS = 1;
  localparam int DG_VIDEO_DIS_POS = 0;
  localparam logic [7:0] DG_RESET = 8'h60;
  localparam logic [7:0] DG_WRITE_MASK = 8'hBF;
  localparam logic [7:0] DG_READ_ONE = 8'h40;

  // ****************************************
  // Capability head values
  // ****************************************
  localparam logic [7:0] CAP_ID_VALUE = 8'h01;
  localparam logic [7:0] NEXT_CAP_VALUE = 8'h00;

  // ****************************************
  // Interrupt signalling modes
  // ****************************************
  localparam logic [1:0] IRQ_MODE_PAR_PCI = 2'h0;
  localparam logic [1:0] IRQ_MODE_PAR_BOTH = 2'h1;
  localparam logic [1:0] IRQ_MODE_SER_IRQ = 2'h2;
  localparam logic [1:0] IRQ_MODE_SER_BOTH = 2'h3;

  // ****************************************
  // Timing counts in clock cycles
  // ****************************************
  localparam int RETRY_LAT_SHORT = 16;
  localparam int RETRY_LAT_LONG = 64;
  localparam int DISCARD_SHORT_LOG2 = 10;
  localparam int DISCARD_LONG_LOG2 = 15;
  localparam int DISCARD_SHORT_CYCLES = 2 ** DISCARD_SHORT_LOG2;
  localparam int DISCARD_LONG_CYCLES = 2 ** DISCARD_LONG_LOG2;

  // Dword base of a byte offset
  function automatic logic [7:0] dword_of(input logic [7:0] ofs);
    dword_of = {ofs[7:2], 2'h0};
  endfunction : dword_of

endpackage : bridge_diag_cfg_pkg

//--- core/discard_timer.sv
/*
  Discard timer for one side of the bridge.
  Assumes start and done are single-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
module discard_timer #(
  parameter int CNT_W = 16,
  parameter int LONG_CYCLES = 32768,
  parameter int SHORT_CYCLES = 1024
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_done,
  input wire logic i_short_sel,
  output logic o_running,
  output logic o_expired
);

  typedef enum logic {TMR_IDLE, TMR_RUN} tmr_state_e;

  tmr_state_e state_ff;
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] limit_ff;
  logic expired_ff;
  logic at_limit;

  assign at_limit = (count_ff == limit_ff);

  // ****************************************
  // State
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_ff <= TMR_IDLE;
    end else begin
      case (state_ff)
        TMR_IDLE: begin
          if (i_start) begin
            state_ff <= TMR_RUN;
          end
        end
        TMR_RUN: begin
          if (i_done || at_limit) begin
            state_ff <= TMR_IDLE;
          end
        end
        default: state_ff <= TMR_IDLE;
      endcase
    end
  end

  // ****************************************
  // Count and limit
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      count_ff <= '0;
      limit_ff <= '0;
    end else if (state_ff == TMR_IDLE && i_start) begin
      count_ff <= '0;
      limit_ff <= i_short_sel ? CNT_W'(SHORT_CYCLES - 1) : CNT_W'(LONG_CYCLES - 1);
    end else if (state_ff == TMR_RUN && !at_limit) begin
      count_ff <= count_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= (state_ff == TMR_RUN) && at_limit && !i_done;
    end
  end

  assign o_running = (state_ff == TMR_RUN);
  assign o_expired = expired_ff;

endmodule : discard_timer

//--- core/irq_route.sv
/*
  Interrupt mode decode and status-change routing.
  Assumes legacy socket register bits are supplied as steady levels.
*/
`timescale 1ns/1ps
module irq_route (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_irq_signalling_select,
  input wire logic i_card_status_change_routing,
  input wire logic i_legacy_803_bit4,
  input wire logic [3:0] i_legacy_805_hi,
  input wire logic i_csc_event,
  output logic o_csc_to_host,
  output logic o_par_pci_en,
  output logic o_par_irq_en,
  output logic o_ser_irq_en,
  output logic o_ser_pci_en
);

  logic csc_ff;
  logic par_pci_ff;
  logic par_irq_ff;
  logic ser_irq_ff;
  logic ser_pci_ff;
  logic csc_route_ok;

  // ****************************************
  // Status-change routing
  // ****************************************
  assign csc_route_ok = i_card_status_change_routing ? (i_legacy_805_hi == 4'h0) // (RULE11)
                                                     : i_legacy_803_bit4; // (RULE11)

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      csc_ff <= 1'b0;
    end else begin
      csc_ff <= i_csc_event && csc_route_ok;
    end
  end

  // ****************************************
  // Signalling mode decode
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      par_pci_ff <= 1'b0;
      par_irq_ff <= 1'b0;
      ser_irq_ff <= 1'b1;
      ser_pci_ff <= 1'b1;
    end else begin
      case (i_irq_signalling_select) // (RULE5)
        bridge_diag_cfg_pkg::IRQ_MODE_PAR_PCI: begin
          par_pci_ff <= 1'b1;
          par_irq_ff <= 1'b0;
          ser_irq_ff <= 1'b0;
          ser_pci_ff <= 1'b0;
        end
        bridge_diag_cfg_pkg::IRQ_MODE_PAR_BOTH: begin
          par_pci_ff <= 1'b1;
          par_irq_ff <= 1'b1;
          ser_irq_ff <= 1'b0;
          ser_pci_ff <= 1'b0;
        end
        bridge_diag_cfg_pkg::IRQ_MODE_SER_IRQ: begin
          par_pci_ff <= 1'b1;
          par_irq_ff <= 1'b0;
          ser_irq_ff <= 1'b1;
          ser_pci_ff <= 1'b0;
        end
        default: begin
          par_pci_ff <= 1'b0;
          par_irq_ff <= 1'b0;
          ser_irq_ff <= 1'b1;
          ser_pci_ff <= 1'b1;
        end
      endcase
    end
  end

  assign o_csc_to_host = csc_ff;
  assign o_par_pci_en = par_pci_ff;
  assign o_par_irq_en = par_irq_ff;
  assign o_ser_irq_en = ser_irq_ff;
  assign o_ser_pci_en = ser_pci_ff;

endmodule : irq_route

//--- dv/bridge_diag_cfg_sva.sv
/*
  Checker for the device control, diagnostic and capability-head slice.
  Assumes a bind to bridge_diag_cfg_regs on its single clock.
*/
`timescale 1ns/1ps
module bridge_diag_cfg_sva (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic o_cfg_ack,
  input wire logic i_sw_socket_power_off,
  input wire logic o_socket_power_off,
  input wire logic o_par_pci_en,
  input wire logic o_par_irq_en,
  input wire logic o_ser_irq_en,
  input wire logic o_ser_pci_en,
  input wire logic i_csc_event,
  input wire logic o_csc_to_host,
  input wire logic i_host_retry,
  input wire logic o_delayed_txn_capture,
  input wire logic i_target_wait,
  input wire logic o_retry_latency_expired
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_ack_follows: assert property ((i_cfg_rd || i_cfg_wr) |=> o_cfg_ack)
    else $error("ack missing after access");
  a_ack_only: assert property (!(i_cfg_rd || i_cfg_wr) |=> !o_cfg_ack)
    else $error("ack without access");
  a_cap_head: assert property ((i_cfg_rd && i_cfg_addr[7:2] == 6'h28) |=> o_cfg_rdata == 32'h1)
    else $error("capability head read wrong");
  a_rsvd_bits: assert property ((i_cfg_rd && i_cfg_addr[7:2] == 6'h24) |=> o_cfg_rdata[30] && !o_cfg_rdata[20])
    else $error("reserved bit read wrong");
  a_power_cause: assert property ($rose(o_socket_power_off) |-> $past(i_sw_socket_power_off))
    else $error("power off without request");
  a_mode_legal: assert property ({o_par_pci_en, o_par_irq_en, o_ser_irq_en, o_ser_pci_en} inside {4'h8, 4'hC, 4'hA, 4'h3})
    else $error("illegal interrupt mode outputs");
  a_csc_cause: assert property (o_csc_to_host |-> $past(i_csc_event))
    else $error("status change without event");
  a_capture_cause: assert property (o_delayed_txn_capture |-> $past(i_host_retry))
    else $error("capture without retry");
  a_retry_wait: assert property (o_retry_latency_expired |-> $past(i_target_wait, 16) ##1 !o_retry_latency_expired)
    else $error("latency expiry too early or too long");
endmodule : bridge_diag_cfg_sva

//--- dv/cfg_host_model.sv
/*
  Host model issuing configuration reads and writes as strobes.
  Assumes callers enter xfer just after a rising clock edge.
*/
`timescale 1ns/1ps
module cfg_host_model (
  input wire logic i_mclk,
  input wire logic i_ack,
  input wire logic [31:0] i_rdata,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [3:0] o_be,
  output logic [31:0] o_wdata
);
  int ack_miss = 0;
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 8'hFF;
    o_be = 4'h0;
    o_wdata = 32'h0;
  end
  // ****************************************
  // One strobe, answer taken with ack
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d, output logic [31:0] q);
    o_rd = !w;
    o_wr = w;
    o_addr = a;
    o_be = b;
    o_wdata = d;
    @(posedge i_mclk);
    #1;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = ~a;
    o_be = ~b;
    o_wdata = ~d;
    @(posedge i_mclk);
    if (i_ack !== 1'b1) ack_miss++;
    q = i_rdata;
    #1;
  endtask : xfer
endmodule : cfg_host_model

//--- dv/tb.sv
/*
  Self-checking bench for bridge_diag_cfg_regs driven by a host model.
  Assumes discard counts shortened to 64 and 16 cycles.
*/
`timescale 1ns/1ps
module tb;
  localparam int LONG_N = 64;
  localparam int SHORT_N = 16;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_cfg_rd, i_cfg_wr, o_cfg_ack, o_cfg_hit;
  logic [7:0] i_cfg_addr;
  logic [3:0] i_cfg_be, i_legacy_805_hi, modes;
  logic [31:0] i_cfg_wdata, o_cfg_rdata, d, q;
  logic [15:0] i_vendor_id, i_device_id;
  logic i_in_d3, i_sw_socket_power_off, i_sw_socket_power_on, o_socket_power_off;
  logic o_low_voltage_socket_capable, o_diag_io_width_select, o_std_video_model_en;
  logic o_par_pci_en, o_par_irq_en, o_ser_irq_en, o_ser_pci_en;
  logic i_csc_event, i_legacy_803_bit4, o_csc_to_host, i_target_wait;
  logic i_host_retry, o_delayed_txn_capture, i_host_master_return, i_card_retry;
  logic i_card_master_return, o_host_discard_expired, o_card_discard_expired;
  logic o_retry_latency_expired;
  logic [2:0] evts;
  logic [31:0] seed = 32'h79A16AB6;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  assign modes = {o_par_pci_en, o_par_irq_en, o_ser_irq_en, o_ser_pci_en};
  assign evts = {o_retry_latency_expired, o_card_discard_expired, o_host_discard_expired};
  always #10 i_mclk = ~i_mclk;

  bridge_diag_cfg_regs #(.DISCARD_LONG_CYCLES(LONG_N), .DISCARD_SHORT_CYCLES(SHORT_N))
    bridge_diag_cfg_regs_i (.i_mclk, .i_rst_n, .i_cfg_rd, .i_cfg_wr, .i_cfg_addr, .i_cfg_be,
    .i_cfg_wdata, .o_cfg_rdata, .o_cfg_ack, .o_cfg_hit, .i_vendor_id, .i_device_id, .i_in_d3,
    .i_sw_socket_power_off, .i_sw_socket_power_on, .o_socket_power_off,
    .o_low_voltage_socket_capable, .o_diag_io_width_select, .o_par_pci_en, .o_par_irq_en,
    .o_ser_irq_en, .o_ser_pci_en, .i_csc_event, .i_legacy_803_bit4, .i_legacy_805_hi,
    .o_csc_to_host, .i_host_retry, .o_delayed_txn_capture, .i_host_master_return,
    .i_card_retry, .i_card_master_return, .o_host_discard_expired, .o_card_discard_expired,
    .i_target_wait, .o_retry_latency_expired, .o_std_video_model_en);
  cfg_host_model cfg_host_model_i (.i_mclk, .i_ack(o_cfg_ack), .i_rdata(o_cfg_rdata),
    .o_rd(i_cfg_rd), .o_wr(i_cfg_wr), .o_addr(i_cfg_addr), .o_be(i_cfg_be),
    .o_wdata(i_cfg_wdata));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [3:0] mode_of(input logic [1:0] m);
    return m == 2'h3 ? 4'h3 : {1'b1, m == 2'h1, m == 2'h2, 1'b0};
  endfunction : mode_of
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task finish_test;
    $display("Checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task tick;
    @(posedge i_mclk);
    #1;
  endtask : tick
  task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    cfg_host_model_i.xfer(1'b1, a, b, v, q);
  endtask : wr
  task rd(input logic [7:0] a);
    cfg_host_model_i.xfer(1'b0, a, 4'h0, 32'h0, q);
  endtask : rd
  task dg(input logic [7:0] v);
    wr(8'h90, 4'h8, {v, 24'h0});
  endtask : dg
  task count_evt(input int b, input int s, output int c);
    c = s;
    repeat (150) begin
      if (evts[b]) break;
      tick;
      c++;
    end
  endtask : count_evt
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      finish_test;
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {i_in_d3, i_sw_socket_power_off, i_sw_socket_power_on, i_csc_event} = '0;
    {i_legacy_803_bit4, i_legacy_805_hi, i_target_wait, i_host_retry} = '0;
    {i_host_master_return, i_card_retry, i_card_master_return} = '0;
    {i_device_id, i_vendor_id} = rnd();
    repeat (8) @(posedge i_mclk);
    #1;
    i_rst_n = 1'b1;
    chk("mode_rst", 4'h3, modes);
    chk("levels_rst", 3'h7, {o_low_voltage_socket_capable, o_diag_io_width_select,
      o_std_video_model_en});
    chk("hit_idle", 1'b0, o_cfg_hit);
    rd(8'h90);
    chk("regs_rst", 32'h6066_0000, q);
    rd(8'h00);
    chk("id_rst", {i_device_id, i_vendor_id}, q);
    wr(8'hA0, 4'hF, rnd());
    rd(8'hA1);
    chk("cap_head", 32'h1, q);
    wr(8'h6F, 4'hF, rnd());
    rd(8'h6F);
    chk("unmapped", 32'h0, q);
    chk("hit", 1'b1, o_cfg_hit);
    for (int i = 0; i < 12; i++) begin
      d = rnd() & 32'hFFF6_FFFF;
      d[18:17] = i[1:0];
      wr(8'h90, 4'hC, d);
      chk("levels", {d[22], d[21], !d[24]}, {o_low_voltage_socket_capable,
        o_diag_io_width_select, o_std_video_model_en});
      rd(8'h90);
      chk("regs", {d[31:24] & 8'hBF | 8'h40, d[23:16] & 8'hEF, 16'h0}, q);
      chk("mode", mode_of(d[18:17]), modes);
      rd(8'h00);
      chk("id", d[31] ? 32'hFFFF_FFFF : {i_device_id, i_vendor_id}, q);
    end
    for (int j = 0; j < 4; j++) begin
      wr(8'h90, 4'h4, {8'h0, j[0], 7'h66, 16'h0});
      i_in_d3 = j[1];
      i_sw_socket_power_off = 1'b1;
      tick;
      i_sw_socket_power_off = 1'b0;
      chk("power_off", !(j[0] && j[1]), o_socket_power_off);
      i_sw_socket_power_on = 1'b1;
      tick;
      i_sw_socket_power_on = 1'b0;
      chk("power_on", 1'b0, o_socket_power_off);
    end
    for (int j = 0; j < 8; j++) begin
      dg({2'h0, j[0], 5'h0});
      i_legacy_803_bit4 = j[1];
      i_legacy_805_hi = j[2] ? 4'(rnd()) | 4'h1 : 4'h0;
      i_csc_event = 1'b1;
      tick;
      i_csc_event = 1'b0;
      chk("csc", j[0] ? !j[2] : j[1], o_csc_to_host);
    end
    for (int k = 0; k < 5; k++) begin
      dg(k == 4 ? 8'h10 : {5'h0, k[1], k[1], 1'b0});
      i_host_retry = !k[0];
      i_card_retry = k[0];
      tick;
      {i_host_retry, i_card_retry} = 2'h0;
      if (k == 4) chk("capture_off", 1'b0, o_delayed_txn_capture);
      else if (!k[0]) chk("capture", 1'b1, o_delayed_txn_capture);
      if (k < 4) count_evt(k[0], 1, n);
      if (k < 4) chk("discard", k[1] ? SHORT_N + 1 : LONG_N + 1, n);
    end
    dg(8'h02);
    i_host_retry = 1'b1;
    tick;
    i_host_retry = 1'b0;
    i_host_master_return = 1'b1;
    tick;
    i_host_master_return = 1'b0;
    count_evt(0, 2, n);
    chk("returned", 152, n);
    for (int k = 0; k < 2; k++) begin
      dg({4'h0, k[0], 3'h0});
      i_target_wait = 1'b1;
      count_evt(2, 0, n);
      chk("latency", k ? 64 : 16, n);
      i_target_wait = 1'b0;
      tick;
    end
    dg(8'h00);
    rd(8'h90);
    chk("diag_zero", 8'h40, q[31:24]);
    chk("ack_miss", 32'h0, cfg_host_model_i.ack_miss);
    finish_test;
  end
endmodule : tb

bind bridge_diag_cfg_regs bridge_diag_cfg_sva bridge_diag_cfg_sva_i (.i_mclk, .i_rst_n,
  .i_cfg_rd, .i_cfg_wr, .i_cfg_addr, .o_cfg_rdata, .o_cfg_ack, .i_sw_socket_power_off,
  .o_socket_power_off, .o_par_pci_en, .o_par_irq_en, .o_ser_irq_en, .o_ser_pci_en,
  .i_csc_event, .o_csc_to_host, .i_host_retry, .o_delayed_txn_capture, .i_target_wait,
  .o_retry_latency_expired);
